// >>> hw/rud_pkg.sv
// Shared constants and types for the rotate unit datapath
package rud_pkg;

    // Data path
    localparam int          DATA_W         = 16;
    localparam int          NUM_WORK       = 16;
    localparam int          FILE_ADDR_MAX  = 8191;

    // APB register offsets (byte addresses)
    localparam logic [31:0] OFF_OPCODE     = 32'h0000_0000;
    localparam logic [31:0] OFF_STATUS     = 32'h0000_0004;
    localparam logic [31:0] OFF_INFO       = 32'h0000_0008;
    localparam logic [31:0] OFF_WORK_BASE  = 32'h0000_0040;
    localparam logic [31:0] OFF_DATA_BASE  = 32'h0001_0000;

    // Reset values
    localparam logic [15:0] STATUS_RESET   = 16'h0000;
    localparam logic [23:0] OPCODE_RESET   = 24'h00_0000;
    localparam logic [15:0] WORK_RESET     = 16'h0000;

    // Opcode high byte of each rotate group
    localparam logic [7:0]  OPC_F_LEFT     = 8'hd6;
    localparam logic [7:0]  OPC_F_RIGHT    = 8'hd7;
    localparam logic [7:0]  OPC_W_LEFT     = 8'hd2;
    localparam logic [7:0]  OPC_W_RIGHT    = 8'hd3;

    // Opcode field positions
    localparam int          OPC_HI_LSB     = 16;
    localparam int          OPC_VIA_BIT    = 15;
    localparam int          OPC_SIZE_BIT   = 14;
    localparam int          OPC_DEST_BIT   = 13;
    localparam int          OPC_FILE_MSB   = 12;
    localparam int          OPC_Q_LSB      = 11;
    localparam int          OPC_D_LSB      = 7;
    localparam int          OPC_P_LSB      = 4;
    localparam int          OPC_S_LSB      = 0;

    // Status register bit positions
    localparam int          ST_C_BIT       = 0;
    localparam int          ST_Z_BIT       = 1;
    localparam int          ST_N_BIT       = 3;

    // Info register bit positions
    localparam int          INFO_ILLEGAL   = 0;

    // Pointer steps
    localparam logic [15:0] STEP_BYTE      = 16'h0001;
    localparam logic [15:0] STEP_WORD      = 16'h0002;

    typedef enum logic [4:0] {
        ROT_NONE        = 5'h01,
        ROT_LEFT_PLAIN  = 5'h02,
        ROT_LEFT_VIA_C  = 5'h04,
        ROT_RIGHT_PLAIN = 5'h08,
        ROT_RIGHT_VIA_C = 5'h10
    } rud_rot_op_t;

    typedef enum logic [2:0] {
        AM_DIRECT  = 3'h0,
        AM_IND     = 3'h1,
        AM_POSTINC = 3'h2,
        AM_POSTDEC = 3'h3,
        AM_PREINC  = 3'h4,
        AM_PREDEC  = 3'h5
    } rud_amode_t;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
    } rud_flags_t;

    typedef struct packed {
        logic [15:0] result;
        rud_flags_t  flags;
    } rud_rot_out_t;

endpackage

// >>> hw/rud_rotate_core.sv
// Combinational one-bit rotate with flag generation
`timescale 1ns/1ps
module rud_rotate_core (
    // Request
    input  wire logic               byte_op,
    input  wire logic [15:0]        operand,
    input  wire logic               carry_in,
    input  wire rud_pkg::rud_rot_op_t op,
    // Answer
    output rud_pkg::rud_rot_out_t   out
);
    logic [15:0] w_res;
    logic [7:0]  b_res;
    logic        top;
    logic        c_new;

    always_comb begin
        top   = byte_op ? operand[7] : operand[15];
        w_res = operand;
        b_res = operand[7:0];
        c_new = carry_in;
        unique case (op)
            rud_pkg::ROT_LEFT_PLAIN: begin
                w_res = {operand[14:0], operand[15]};
                b_res = {operand[6:0], operand[7]};
            end
            rud_pkg::ROT_LEFT_VIA_C: begin
                w_res = {operand[14:0], carry_in};
                b_res = {operand[6:0], carry_in};
                c_new = top;
            end
            rud_pkg::ROT_RIGHT_PLAIN: begin
                w_res = {operand[0], operand[15:1]};
                b_res = {operand[0], operand[7:1]};
            end
            rud_pkg::ROT_RIGHT_VIA_C: begin
                w_res = {carry_in, operand[15:1]};
                b_res = {carry_in, operand[7:1]};
                c_new = operand[0];
            end
            rud_pkg::ROT_NONE: begin
                w_res = operand;
            end
        endcase
        out.result  = byte_op ? {8'h00, b_res} : w_res;
        out.flags.n = byte_op ? b_res[7] : w_res[15];
        out.flags.z = byte_op ? (b_res == 8'h00) : (w_res == 16'h0000);
        out.flags.c = c_new;
    end

endmodule

// >>> hw/rud_rotate_unit.sv
// Rotate unit datapath: APB slave, working registers, data space, status
// Functional notes
// - Size bit zero selects word operation, one selects byte operation.
// - File forms: destination bit zero targets default register, one the file.
// - File forms take the file address from the low opcode field, 0..8191.
// - File-form result goes to the default register or back to the file.
// - The default working register is working register zero.
// - File rotate-left plain: shift up, top bit to bit 0, N and Z only.
// - Register rotate-left plain: shift up, top bit to bit 0, carry kept.
// - File rotate-right via carry: old carry enters top bit.
// - File rotate-right via carry: carry from bit 0, N and Z from result.
// - Register rotate-right via carry: old carry to top, bit 0 to carry.
// - File rotate-right plain: shift down, bit 0 to top bit, N and Z only.
// - Register rotate-right plain: bit 0 to top, carry kept, N and Z.
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module rud_rotate_unit #(
    parameter int DATA_WORDS = 4096
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Status flags
    output logic      [15:0] status_register
);
    localparam int AW = $clog2(DATA_WORDS);

    logic [15:0] work_reg   [rud_pkg::NUM_WORK];
    logic [15:0] work_next  [rud_pkg::NUM_WORK];
    logic [15:0] mem_reg    [DATA_WORDS];
    logic [15:0] status_reg;
    logic [15:0] status_next;
    logic [23:0] opcode_reg;
    logic [23:0] opcode_next;
    logic        illegal_reg;
    logic        illegal_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        err_reg;
    logic        err_next;

    // Bus decode
    logic        setup;
    logic        access;
    logic        hit_opcode;
    logic        hit_status;
    logic        hit_info;
    logic        hit_work;
    logic        hit_mem;
    logic        mapped;
    logic [3:0]  bus_work_idx;
    logic [AW-1:0] bus_mem_idx;

    assign setup        = psel && !penable;
    assign access       = psel && penable;
    assign hit_opcode   = (paddr == rud_pkg::OFF_OPCODE);
    assign hit_status   = (paddr == rud_pkg::OFF_STATUS);
    assign hit_info     = (paddr == rud_pkg::OFF_INFO);
    assign hit_work     = (paddr[31:6] == rud_pkg::OFF_WORK_BASE[31:6]) && (paddr[1:0] == 2'h0);
    assign hit_mem      = (paddr >= rud_pkg::OFF_DATA_BASE)
                        && (paddr < rud_pkg::OFF_DATA_BASE + 32'(DATA_WORDS * 4))
                        && (paddr[1:0] == 2'h0);
    assign mapped       = hit_opcode || hit_status || hit_info || hit_work || hit_mem;
    assign bus_work_idx = paddr[5:2];
    assign bus_mem_idx  = AW'((paddr - rud_pkg::OFF_DATA_BASE) >> 2);

    // Opcode decode
    logic [7:0]  opc_hi;
    logic        opc_via;
    logic        opc_byte;
    logic        opc_dest_file;
    logic [15:0] file_addr;
    logic [2:0]  q_mode;
    logic [2:0]  p_mode;
    logic [3:0]  d_idx;
    logic [3:0]  s_idx;
    logic        f_form;
    logic        w_form;
    logic        legal;
    logic        exec;
    rud_pkg::rud_rot_op_t rot_op;
    assign opc_hi        = pwdata[rud_pkg::OPC_HI_LSB +: 8];
    assign opc_via       = pwdata[rud_pkg::OPC_VIA_BIT];
    assign opc_byte      = pwdata[rud_pkg::OPC_SIZE_BIT];
    assign opc_dest_file = pwdata[rud_pkg::OPC_DEST_BIT];
    assign file_addr     = {3'h0, pwdata[rud_pkg::OPC_FILE_MSB:0]};
    assign q_mode        = pwdata[rud_pkg::OPC_Q_LSB +: 3];
    assign d_idx         = pwdata[rud_pkg::OPC_D_LSB +: 4];
    assign p_mode        = pwdata[rud_pkg::OPC_P_LSB +: 3];
    assign s_idx         = pwdata[rud_pkg::OPC_S_LSB +: 4];
    assign f_form        = (opc_hi == rud_pkg::OPC_F_LEFT) || (opc_hi == rud_pkg::OPC_F_RIGHT);
    assign w_form        = (opc_hi == rud_pkg::OPC_W_LEFT) || (opc_hi == rud_pkg::OPC_W_RIGHT);
    assign rot_op        = (opc_hi == rud_pkg::OPC_F_LEFT || opc_hi == rud_pkg::OPC_W_LEFT)
                         ? (opc_via ? rud_pkg::ROT_LEFT_VIA_C : rud_pkg::ROT_LEFT_PLAIN)
                         : (opc_hi == rud_pkg::OPC_F_RIGHT || opc_hi == rud_pkg::OPC_W_RIGHT)
                         ? (opc_via ? rud_pkg::ROT_RIGHT_VIA_C : rud_pkg::ROT_RIGHT_PLAIN)
                         : rud_pkg::ROT_NONE;

    // Reserved addressing codes make a register form illegal
    assign legal = f_form || (w_form && p_mode <= rud_pkg::AM_PREDEC
                                     && q_mode <= rud_pkg::AM_PREDEC);
    assign exec  = access && pwrite && hit_opcode && legal;

    // Effective addresses and pointer updates
    logic [15:0] step;
    logic [15:0] src_ptr;
    logic [15:0] dst_ptr;
    logic [15:0] src_ea;
    logic [15:0] dst_ea;
    logic [15:0] src_post;
    logic [15:0] dst_post;

    function automatic logic [15:0] ea_of(input logic [2:0] m, input logic [15:0] ptr,
                                          input logic [15:0] stp);
        unique case (m)
            rud_pkg::AM_PREINC: ea_of = ptr + stp;
            rud_pkg::AM_PREDEC: ea_of = ptr - stp;
            default:            ea_of = ptr;
        endcase
    endfunction

    function automatic logic [15:0] post_of(input logic [2:0] m, input logic [15:0] ptr,
                                            input logic [15:0] stp);
        unique case (m)
            rud_pkg::AM_POSTINC, rud_pkg::AM_PREINC: post_of = ptr + stp;
            rud_pkg::AM_POSTDEC, rud_pkg::AM_PREDEC: post_of = ptr - stp;
            default:                                 post_of = ptr;
        endcase
    endfunction

    assign step     = opc_byte ? rud_pkg::STEP_BYTE : rud_pkg::STEP_WORD;
    assign src_ptr  = work_reg[s_idx];
    assign dst_ptr  = work_reg[d_idx];
    assign src_ea   = ea_of(p_mode, src_ptr, step);
    assign dst_ea   = ea_of(q_mode, dst_ptr, step);
    assign src_post = post_of(p_mode, src_ptr, step);
    assign dst_post = post_of(q_mode, dst_ptr, step);

    // Operand fetch
    logic [15:0] rd_addr;
    logic [15:0] rd_word;
    logic [15:0] operand;
    logic        from_mem;
    rud_pkg::rud_rot_out_t rot;
    assign from_mem = f_form || (p_mode != rud_pkg::AM_DIRECT);
    assign rd_addr  = f_form ? file_addr : src_ea;
    assign rd_word  = from_mem ? mem_reg[rd_addr[AW:1]] : src_ptr;
    assign operand  = !opc_byte ? rd_word
                    : (from_mem && rd_addr[0]) ? {8'h00, rd_word[15:8]}
                    : {8'h00, rd_word[7:0]};

    rud_rotate_core u_core (
        .byte_op  (opc_byte),
        .operand  (operand),
        .carry_in (status_reg[rud_pkg::ST_C_BIT]),
        .op       (rot_op),
        .out      (rot)
    );

    // Write-back steering
    logic          wr_to_work;
    logic [3:0]    wr_work_idx;
    logic [15:0]   wr_addr;
    logic          mem_we;
    logic [AW-1:0] mem_widx;
    logic [15:0]   mem_wdata;
    logic [15:0]   mem_old;
    assign wr_to_work  = f_form ? !opc_dest_file : (q_mode == rud_pkg::AM_DIRECT);
    assign wr_work_idx = f_form ? 4'h0 : d_idx;
    assign wr_addr     = f_form ? file_addr : dst_ea;
    assign mem_old     = mem_reg[wr_addr[AW:1]];

    always_comb begin
        mem_we    = 1'b0;
        mem_widx  = bus_mem_idx;
        mem_wdata = pwdata[15:0];
        if (access && pwrite && hit_mem) begin
            mem_we = 1'b1;
        end else if (exec && !wr_to_work) begin
            mem_we   = 1'b1;
            mem_widx = wr_addr[AW:1];
            mem_wdata = !opc_byte ? rot.result
                      : wr_addr[0] ? {rot.result[7:0], mem_old[7:0]}
                      : {mem_old[15:8], rot.result[7:0]};
        end
    end

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem_reg[mem_widx] <= mem_wdata;
        end
    end

    // Working registers, status and bus state
    always_comb begin
        work_next    = work_reg;
        status_next  = status_reg;
        opcode_next  = opcode_reg;
        illegal_next = illegal_reg;
        if (access && pwrite) begin
            if (hit_work) begin
                work_next[bus_work_idx] = pwdata[15:0];
            end
            if (hit_status) begin
                status_next = pwdata[15:0];
            end
            if (hit_info && pwdata[rud_pkg::INFO_ILLEGAL]) begin
                illegal_next = 1'b0;
            end
            if (hit_opcode) begin
                opcode_next = pwdata[23:0];
                if (!legal) begin
                    illegal_next = 1'b1;
                end
            end
        end
        if (exec) begin
            if (w_form && p_mode != rud_pkg::AM_DIRECT) begin
                work_next[s_idx] = src_post;
            end
            if (w_form && q_mode != rud_pkg::AM_DIRECT) begin
                work_next[d_idx] = dst_post;
            end
            if (wr_to_work) begin
                work_next[wr_work_idx] = opc_byte ? {work_reg[wr_work_idx][15:8], rot.result[7:0]}
                                                  : rot.result;
            end
            status_next[rud_pkg::ST_N_BIT] = rot.flags.n;
            status_next[rud_pkg::ST_Z_BIT] = rot.flags.z;
            status_next[rud_pkg::ST_C_BIT] = rot.flags.c;
        end
    end

    always_comb begin
        prdata_next = 32'h0000_0000;
        err_next    = !mapped;
        if (hit_opcode) begin
            prdata_next = {8'h00, opcode_reg};
        end else if (hit_status) begin
            prdata_next = {16'h0000, status_reg};
        end else if (hit_info) begin
            prdata_next = {31'h0000_0000, illegal_reg};
        end else if (hit_work) begin
            prdata_next = {16'h0000, work_reg[bus_work_idx]};
        end else if (hit_mem) begin
            prdata_next = {16'h0000, mem_reg[bus_mem_idx]};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < rud_pkg::NUM_WORK; i++) begin
                work_reg[i] <= rud_pkg::WORK_RESET;
            end
            status_reg  <= rud_pkg::STATUS_RESET;
            opcode_reg  <= rud_pkg::OPCODE_RESET;
            illegal_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            err_reg     <= 1'b0;
        end else begin
            work_reg    <= work_next;
            status_reg  <= status_next;
            opcode_reg  <= opcode_next;
            illegal_reg <= illegal_next;
            if (setup) begin
                prdata_reg <= prdata_next;
                err_reg    <= err_next;
            end
        end
    end

    assign prdata          = prdata_reg;
    assign pslverr         = err_reg && access;
    assign pready          = 1'b1;
    assign status_register = status_reg;

    // Checks
    property p_byte_flags;
        @(posedge clk) disable iff (rst)
        exec && opc_byte |=> status_reg[rud_pkg::ST_N_BIT] == $past(rot.result[7])
                             && $past(rot.result[15:8]) == 8'h00;
    endproperty
    a_byte_flags: assert property (p_byte_flags) else $error("byte N flag wrong");
    property p_default_dest;
        @(posedge clk) disable iff (rst)
        exec && f_form && !opc_dest_file && !opc_byte
            |=> work_reg[0] == $past(rot.result);
    endproperty
    a_default_dest: assert property (p_default_dest) else $error("W0 not written");
    property p_file_dest;
        @(posedge clk) disable iff (rst)
        exec && f_form && opc_dest_file && !opc_byte
            |=> mem_reg[$past(file_addr[AW:1])] == $past(rot.result) && $stable(work_reg[0]);
    endproperty
    a_file_dest: assert property (p_file_dest) else $error("file not written");
    property p_left_plain;
        @(posedge clk) disable iff (rst)
        exec && rot_op == rud_pkg::ROT_LEFT_PLAIN && !opc_byte
            |-> rot.result[0] == operand[15] ##1 $stable(status_reg[rud_pkg::ST_C_BIT]);
    endproperty
    a_left_plain: assert property (p_left_plain) else $error("left rotate wrong");
    property p_right_via;
        @(posedge clk) disable iff (rst)
        exec && rot_op == rud_pkg::ROT_RIGHT_VIA_C && !opc_byte
            |=> status_reg[rud_pkg::ST_C_BIT] == $past(operand[0])
                && $past(rot.result[15]) == $past(status_reg[rud_pkg::ST_C_BIT]);
    endproperty
    a_right_via: assert property (p_right_via) else $error("carry rotate wrong");
    property p_right_plain;
        @(posedge clk) disable iff (rst)
        exec && rot_op == rud_pkg::ROT_RIGHT_PLAIN
            |=> status_reg[rud_pkg::ST_C_BIT] == $past(status_reg[rud_pkg::ST_C_BIT])
                && $past(rot.result[0]) == $past(operand[1]);
    endproperty
    a_right_plain: assert property (p_right_plain) else $error("carry changed");
    property p_zero_flag;
        @(posedge clk) disable iff (rst)
        exec |=> status_reg[rud_pkg::ST_Z_BIT] == ($past(rot.result) == 16'h0000);
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("Z flag wrong");
    property p_post_inc;
        @(posedge clk) disable iff (rst)
        exec && w_form && p_mode == rud_pkg::AM_POSTINC && s_idx != d_idx
            |=> work_reg[$past(s_idx)] == $past(src_ptr) + $past(step);
    endproperty
    a_post_inc: assert property (p_post_inc) else $error("pointer not updated");

endmodule

// >>> test/test_rud_rotate_unit.sv
// Self-checking bench for the rotate unit over its APB register map
`timescale 1ns/1ps
module test_rud_rotate_unit;
    localparam int WORDS = 64;

    logic        clk;
    logic        rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] status_register;
    logic [31:0] rdata;
    logic        rerr;
    int          miscompares;
    int          compares;

    rud_rotate_unit #(
        .DATA_WORDS (WORDS)
    ) rud_rotate_unit_inst (
        .clk             (clk),
        .rst             (rst),
        .psel            (psel),
        .penable         (penable),
        .pwrite          (pwrite),
        .paddr           (paddr),
        .pwdata          (pwdata),
        .prdata          (prdata),
        .pready          (pready),
        .pslverr         (pslverr),
        .status_register (status_register)
    );

    always #25 clk = ~clk;

    task automatic end_of_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; entered right after a rising edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int i;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 16) begin
            miscompares++;
            $display("mismatch pready expected 1 seen timeout");
            end_of_test();
        end
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, exp, rdata);
    endtask

    function automatic logic [31:0] default_working_register(input int n);
        return rud_pkg::OFF_WORK_BASE + 32'(4 * n);
    endfunction

    function automatic logic [31:0] dmem(input int i);
        return rud_pkg::OFF_DATA_BASE + 32'(4 * i);
    endfunction

    // Load flags, execute, then check flags through the bus and the port
    task automatic rot(input logic [23:0] opc, input logic [15:0] st, input logic [15:0] exp);
        wr(rud_pkg::OFF_STATUS, {16'h0000, st});
        wr(rud_pkg::OFF_OPCODE, {8'h00, opc});
        rdchk("status", rud_pkg::OFF_STATUS, {16'h0000, exp});
        chk("status_port", {16'h0000, exp}, {16'h0000, status_register});
    endtask

    initial begin
        clk         = 1'b0;
        rst         = 1'b1;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 32'h0000_0000;
        pwdata      = 32'h0000_0000;
        miscompares = 0;
        compares    = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rdchk("status_rst", rud_pkg::OFF_STATUS, 32'h0000_0000);
        rdchk("opcode_rst", rud_pkg::OFF_OPCODE, 32'h0000_0000);
        rdchk("w0_rst", default_working_register(0), 32'h0000_0000);
        $display("test reset done");

        // File forms on data word 16 (byte address 0x20) and data word 63
        wr(dmem(16), 32'h0000_216e);
        rot(24'hd60020, 16'h0001, 16'h0001);
        rdchk("w0", default_working_register(0), 32'h0000_42dc);
        rdchk("file", dmem(16), 32'h0000_216e);
        rot(24'hd7a020, 16'h0001, 16'h0008);
        rdchk("file", dmem(16), 32'h0000_90b7);
        rdchk("w0", default_working_register(0), 32'h0000_42dc);
        rot(24'hd76021, 16'h0001, 16'h0001);
        rdchk("file", dmem(16), 32'h0000_48b7);
        wr(dmem(63), 32'h0000_8100);
        rot(24'hd65fff, 16'h0008, 16'h0000);
        rdchk("w0", default_working_register(0), 32'h0000_4203);
        $display("test file_forms done");

        // Register direct forms, byte size
        wr(default_working_register(0), 32'h0000_9976);
        wr(default_working_register(3), 32'h0000_5879);
        rot(24'hd24180, 16'h0001, 16'h0009);
        rdchk("w3", default_working_register(3), 32'h0000_58ec);
        wr(default_working_register(3), 32'h0000_5879);
        rot(24'hd34180, 16'h0001, 16'h0001);
        rdchk("w3", default_working_register(3), 32'h0000_583b);
        wr(default_working_register(0), 32'h0000_0001);
        rot(24'hd3c180, 16'h0000, 16'h0003);
        rdchk("w3", default_working_register(3), 32'h0000_5800);
        $display("test reg_direct done");

        // Register indirect forms with pointer updates, word size
        wr(dmem(4), 32'h0000_c041);
        wr(default_working_register(8), 32'h0000_004e);
        wr(default_working_register(2), 32'h0000_0008);
        rot(24'hd20c22, 16'h0001, 16'h0009);
        rdchk("mem", dmem(39), 32'h0000_8083);
        rdchk("w2", default_working_register(2), 32'h0000_000a);
        wr(default_working_register(2), 32'h0000_0008);
        rot(24'hd38c22, 16'h0001, 16'h0009);
        rdchk("mem", dmem(39), 32'h0000_e020);
        wr(default_working_register(2), 32'h0000_000a);
        rot(24'hd28c52, 16'h0000, 16'h0009);
        rdchk("mem", dmem(39), 32'h0000_8082);
        rdchk("w2", default_working_register(2), 32'h0000_0008);
        // Pre-increment source, post-decrement destination
        wr(default_working_register(2), 32'h0000_0006);
        rot(24'hd31c42, 16'h0000, 16'h0008);
        rdchk("mem", dmem(39), 32'h0000_e020);
        rdchk("w2", default_working_register(2), 32'h0000_0008);
        rdchk("w8", default_working_register(8), 32'h0000_004c);
        $display("test reg_indirect done");

        // Refused accesses and illegal opcode
        apb(1'b0, 32'h0000_0100, 32'h0000_0000);
        chk("unmapped_data", 32'h0000_0000, rdata);
        chk("unmapped_err", 32'h0000_0001, {31'h0, rerr});
        wr(32'h0000_0042, 32'h0000_ffff);
        chk("unaligned_err", 32'h0000_0001, {31'h0, rerr});
        rdchk("w0", default_working_register(0), 32'h0000_0001);
        wr(rud_pkg::OFF_STATUS, 32'h0000_0000);
        wr(rud_pkg::OFF_OPCODE, 32'h00ff_0000);
        rdchk("info", rud_pkg::OFF_INFO, 32'h0000_0001);
        rdchk("status", rud_pkg::OFF_STATUS, 32'h0000_0000);
        wr(rud_pkg::OFF_INFO, 32'h0000_0001);
        rdchk("info", rud_pkg::OFF_INFO, 32'h0000_0000);
        // Reserved destination mode is refused without execution
        wr(rud_pkg::OFF_OPCODE, 32'h00d2_7180);
        rdchk("info", rud_pkg::OFF_INFO, 32'h0000_0001);
        rdchk("w3", default_working_register(3), 32'h0000_5800);
        rdchk("status", rud_pkg::OFF_STATUS, 32'h0000_0000);
        $display("test refusals done");
        end_of_test();
    end
endmodule
